/* File: core/adcc_defines.vh */
// Behaviour
// - Time code n sets loop to 2^(20+n) sample clock cycles, codes above 11 held at 11
// - Reset pin high holds registers at defaults
// - Serial clock used only while reset low
// - Serial data is config input, else standby
// - Port select frames config, ignored under reset
// - Output-enable pin gates data and clock buffers
// - Format pin picks coding and output interface
// - Status pin: range flag, or readback when enabled
// - Bit pairs share one lane, both clock edges
// - Interface field 01/11 overrides the format pin
`ifndef ADCC_DEFINES_VH
`define ADCC_DEFINES_VH

// Register indices; bus byte address is four times the index
`define ADCC_IDX_CTRL     8'h00
`define ADCC_IDX_IFSEL    8'h41
`define ADCC_IDX_OFFS     8'hCF
`define ADCC_IDX_STAT     8'hE0
`define ADCC_IDX_MASK     8'hE1
`define ADCC_IDX_STATE    8'hE2

// Reset values
`define ADCC_CTRL_RST     8'h00
`define ADCC_IFSEL_RST    8'h00
`define ADCC_OFFS_RST     8'h00

// Field positions
`define ADCC_CTRL_READOUT 0
`define ADCC_CTRL_SWRST   1
`define ADCC_IFSEL_MSB    7
`define ADCC_IFSEL_LSB    6
`define ADCC_OFFS_FREEZE  7
`define ADCC_TC_MSB       5
`define ADCC_TC_LSB       2
`define ADCC_OFFS_WMASK   8'hBC
`define ADCC_ST_RANGE     0
`define ADCC_ST_FRAME     1
`define ADCC_ST_LOOP      2

// Interface select codes
`define ADCC_IF_LVDS      2'h1
`define ADCC_IF_CMOS      2'h3

// Timing and sizes
`define ADCC_TC_BASE_LOG2 20
`define ADCC_TC_MAX_CODE  4'hB
`define ADCC_FRAME_LAST   4'hF
`define ADCC_ADDR_LAST    4'h7
`define ADCC_PIN_INIT     9'h018

`endif

/* File: core/adcc_sync.v */
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for pins from outside the clock domain
module adcc_sync #(
  parameter       W    = 9,          // Number of bits
  parameter [8:0] INIT = 9'h000      // Reset level of each bit
) (
  input  wire         clk_i,         // System clock
  input  wire         rst_i,         // Synchronous reset
  input  wire [W-1:0] d_i,           // Asynchronous inputs
  output wire [W-1:0] q_o            // Synchronised outputs
);
  reg [W-1:0] meta_reg;              // First stage, read only by second
  reg [W-1:0] sync_reg;              // Second stage

  // Two flops in series
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= INIT[W-1:0];
      sync_reg <= INIT[W-1:0];
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // adcc_sync
`default_nettype wire

/* File: core/adcc_core.v */
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"
// Control pins, serial configuration port and output lanes of the converter
module adcc_core #(
  parameter TC_BASE_LOG2 = `ADCC_TC_BASE_LOG2  // Log2 of loop cycles at code 0
) (
  input  wire        clk_i,                        // 20 MHz system clock
  input  wire        rst_i,                        // Synchronous reset, high
  input  wire [9:0]  wb_adr_i,                     // Wishbone byte address
  input  wire [31:0] wb_dat_i,                     // Wishbone write data
  output wire [31:0] wb_dat_o,                     // Wishbone read data
  input  wire        wb_we_i,                      // Wishbone write
  input  wire [3:0]  wb_sel_i,                     // Wishbone byte selects
  input  wire        wb_cyc_i,                     // Wishbone cycle
  input  wire        wb_stb_i,                     // Wishbone strobe
  output wire        wb_ack_o,                     // Wishbone acknowledge
  output wire        irq_o,                        // Level interrupt
  input  wire        cfg_reset_i,                  // Hardware reset pin
  input  wire        cfg_serial_clk_i,             // Serial clock pin
  input  wire        cfg_serial_data_in_i,         // Serial data / standby pin
  input  wire        cfg_port_select_i,            // Serial select pin, low active
  input  wire        out_enable_i,                 // Output buffer enable pin
  input  wire [1:0]  format_interface_select_i,    // Bit0 twos compl, bit1 parallel
  input  wire        sample_clock_true_i,          // Sample clock, true
  input  wire        sample_clock_comp_i,          // Sample clock, complement
  input  wire [13:0] adc_data_i,                   // Offset-binary sample
  input  wire        adc_range_i,                  // Out-of-range from converter
  output wire        range_flag_or_readback_o,     // Range flag or readback data
  output wire        forwarded_clock_true_o,       // Forwarded clock, true
  output wire        forwarded_clock_comp_o,       // Forwarded clock, complement
  output wire [6:0]  lane_true_o,                  // Paired-bit lanes, true
  output wire [6:0]  lane_comp_o,                  // Paired-bit lanes, complement
  output wire        lane_oe_o,                    // Differential buffers enabled
  output wire [13:0] cmos_data_o,                  // Parallel data
  output wire        cmos_clock_o,                 // Parallel output clock
  output wire        cmos_oe_o,                    // Parallel buffers enabled
  output wire        standby_o,                    // Standby in direct mode
  output wire        offset_loop_update_o          // Loop time constant elapsed
);
  wire [8:0] pin_s;                                // Synchronised pins
  reg  [8:0] pin_d_reg;                            // Previous synchronised pins
  wire       hwrst_s  = pin_s[0];                  // Reset pin level
  wire       sclk_s   = pin_s[1];                  // Serial clock level
  wire       cfg_serial_data_in_s  = pin_s[2];                  // Serial data level
  wire       sen_s    = pin_s[3];                  // Port select level
  wire       oe_s     = pin_s[4];                  // Output enable level
  wire [1:0] dfs_s    = pin_s[6:5];                // Format select level
  reg        ctrl_readout_reg;                     // Readback enable bit
  reg        swrst_reg;                            // Software reset pulse
  reg  [7:0] ifsel_reg;                            // Interface control register
  reg  [7:0] offs_reg;                             // Offset loop register
  reg  [2:0] stat_reg;                             // Sticky events
  reg  [2:0] mask_reg;                             // Interrupt mask
  reg        irq_reg;                              // Interrupt output flop
  reg        ack_reg;                              // Bus acknowledge
  reg  [31:0] rdat_reg;                            // Bus read data
  reg        sclk_lvl_reg;                         // Sample clock level
  reg        sclk_lvl_d_reg;                       // Delayed sample clock level
  reg  [13:0] word_reg;                            // Formatted sample
  reg  [6:0] lane_reg;                             // Lane drive
  reg        fwd_reg;                              // Forwarded clock drive
  reg  [13:0] cmos_reg;                            // Parallel data drive
  reg        cmos_clk_reg;                         // Parallel clock drive
  reg        range_reg;                            // Captured range flag
  reg        pin_out_reg;                          // Shared status pin drive
  reg  [31:0] loop_cnt_reg;                        // Loop cycle counter
  reg        loop_pulse_reg;                       // Loop elapsed pulse
  reg  [14:0] sh_reg;                              // Serial shift register
  reg  [3:0] bit_cnt_reg;                          // Serial bit counter
  reg  [7:0] rd_sh_reg;                            // Readback shift register
  reg        sdo_reg;                              // Readback bit
  reg        frame_wr_reg;                         // Serial write strobe
  reg  [7:0] frame_adr_reg;                        // Serial write address
  reg  [7:0] frame_dat_reg;                        // Serial write data

  // Pins cross into the clock domain
  adcc_sync #(.W(9), .INIT(`ADCC_PIN_INIT)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sample_clock_comp_i, sample_clock_true_i, format_interface_select_i,
             out_enable_i, cfg_port_select_i, cfg_serial_data_in_i,
             cfg_serial_clk_i, cfg_reset_i}),
    .q_o   (pin_s)
  );

  // Loop length for a time code, held at the last valid code
  function [31:0] tc_limit;
    input [3:0] code;
    reg   [3:0] c;
    begin
      c = (code > `ADCC_TC_MAX_CODE) ? `ADCC_TC_MAX_CODE : code;
      tc_limit = 32'h0000_0001 << (TC_BASE_LOG2 + c);
    end
  endfunction

  // Odd or even bit of each pair
  function [6:0] pick_half;
    input [13:0] w;
    input        odd;
    integer      i;
    begin
      pick_half = 7'h00;
      for (i = 0; i < 7; i = i + 1) begin
        pick_half[i] = w[2*i + odd];
      end
    end
  endfunction

  // Readable configuration registers
  function [7:0] cfg_read;
    input [7:0] idx;
    begin
      case (idx)
        `ADCC_IDX_CTRL:  cfg_read = {7'h00, ctrl_readout_reg};
        `ADCC_IDX_IFSEL: cfg_read = ifsel_reg;
        `ADCC_IDX_OFFS:  cfg_read = offs_reg;
        default:         cfg_read = 8'h00;
      endcase
    end
  endfunction

  // Mode decode
  wire       cfg_mode  = ~hwrst_s;
  wire       standby   = hwrst_s & cfg_serial_data_in_s;
  wire [1:0] if_code   = ifsel_reg[`ADCC_IFSEL_MSB:`ADCC_IFSEL_LSB];
  wire       use_cmos  = (if_code == `ADCC_IF_LVDS) ? 1'b0 :
                         (if_code == `ADCC_IF_CMOS) ? 1'b1 : dfs_s[1];
  wire       twos      = dfs_s[0];
  wire       buf_en    = oe_s & ~standby;
  wire       lvds_en   = buf_en & ~use_cmos;
  wire       cmos_en   = buf_en & use_cmos;
  wire       cfg_clear = rst_i | hwrst_s | swrst_reg;
  wire       clk_rise  = sclk_lvl_reg & ~sclk_lvl_d_reg;
  wire       clk_fall  = ~sclk_lvl_reg & sclk_lvl_d_reg;
  wire       ser_act   = cfg_mode & ~sen_s;
  wire       ser_rise  = ser_act & sclk_s & ~pin_d_reg[1];
  wire       ser_fall  = ser_act & ~sclk_s & pin_d_reg[1];
  wire       bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire       bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0] bus_idx   = wb_adr_i[9:2];
  wire [2:0] events    = {loop_pulse_reg, frame_wr_reg, range_reg & clk_rise};

  // Edge history of synchronised pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_d_reg <= `ADCC_PIN_INIT;
    end else begin
      pin_d_reg <= pin_s;
    end
  end

  // Sample clock level, updated only on a valid differential state
  always @(posedge clk_i) begin
    if (rst_i) begin
      sclk_lvl_reg   <= 1'b0;
      sclk_lvl_d_reg <= 1'b0;
    end else begin
      if (pin_s[7] != pin_s[8]) begin
        sclk_lvl_reg <= pin_s[7];
      end
      sclk_lvl_d_reg <= sclk_lvl_reg;
    end
  end

  // Sample capture, lane multiplexing, parallel output and status pin
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_reg  <= 1'b0;
      word_reg     <= 14'h0000;
      lane_reg     <= 7'h00;
      fwd_reg      <= 1'b0;
      cmos_reg     <= 14'h0000;
      cmos_clk_reg <= 1'b0;
      range_reg    <= 1'b0;
    end else begin
      pin_out_reg <= ctrl_readout_reg ? sdo_reg : range_reg;
      if (clk_rise) begin
        // Offset binary passes, twos complement flips the sign bit
        word_reg  <= twos ? {~adc_data_i[13], adc_data_i[12:0]} : adc_data_i;
        range_reg <= adc_range_i;
      end
      if (!lvds_en) begin
        lane_reg <= 7'h00;
        fwd_reg  <= 1'b0;
      end else if (clk_rise) begin
        lane_reg <= pick_half(word_reg, 1'b0);
        fwd_reg  <= 1'b1;
      end else if (clk_fall) begin
        lane_reg <= pick_half(word_reg, 1'b1);
        fwd_reg  <= 1'b0;
      end
      if (!cmos_en) begin
        cmos_reg     <= 14'h0000;
        cmos_clk_reg <= 1'b0;
      end else if (clk_rise) begin
        cmos_reg     <= word_reg;
        cmos_clk_reg <= 1'b0;
      end else if (clk_fall) begin
        cmos_clk_reg <= 1'b1;
      end
    end
  end

  // Offset loop period counter in sample clock cycles
  always @(posedge clk_i) begin
    if (rst_i || standby) begin
      loop_cnt_reg   <= 32'h0000_0000;
      loop_pulse_reg <= 1'b0;
    end else begin
      loop_pulse_reg <= 1'b0;
      if (clk_rise && !offs_reg[`ADCC_OFFS_FREEZE]) begin
        if (loop_cnt_reg >= tc_limit(offs_reg[`ADCC_TC_MSB:`ADCC_TC_LSB]) - 32'h1) begin
          loop_cnt_reg   <= 32'h0000_0000;
          loop_pulse_reg <= 1'b1;
        end else begin
          loop_cnt_reg <= loop_cnt_reg + 32'h1;
        end
      end
    end
  end

  // Serial port: 8 address then 8 data bits, MSB first
  always @(posedge clk_i) begin
    if (rst_i || !ser_act) begin
      sh_reg        <= 15'h0000;
      bit_cnt_reg   <= 4'h0;
      rd_sh_reg     <= 8'h00;
      sdo_reg       <= 1'b0;
      frame_wr_reg  <= 1'b0;
      frame_adr_reg <= 8'h00;
      frame_dat_reg <= 8'h00;
    end else begin
      frame_wr_reg <= 1'b0;
      if (ser_rise) begin
        sh_reg      <= {sh_reg[13:0], cfg_serial_data_in_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == `ADCC_ADDR_LAST) begin
          rd_sh_reg <= cfg_read({sh_reg[6:0], cfg_serial_data_in_s});
        end
        if (bit_cnt_reg == `ADCC_FRAME_LAST) begin
          frame_wr_reg  <= 1'b1;
          frame_adr_reg <= sh_reg[14:7];
          frame_dat_reg <= {sh_reg[6:0], cfg_serial_data_in_s};
        end
      end else if (ser_fall && bit_cnt_reg[3]) begin
        sdo_reg   <= rd_sh_reg[7];
        rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
      end
    end
  end

  // Configuration registers, serial then bus writes
  always @(posedge clk_i) begin
    if (cfg_clear) begin
      ctrl_readout_reg <= |(`ADCC_CTRL_RST & 8'h01);
      swrst_reg        <= 1'b0;
      ifsel_reg        <= `ADCC_IFSEL_RST;
      offs_reg         <= `ADCC_OFFS_RST;
    end else begin
      swrst_reg <= 1'b0;
      if (frame_wr_reg) begin
        case (frame_adr_reg)
          `ADCC_IDX_CTRL: begin
            ctrl_readout_reg <= frame_dat_reg[`ADCC_CTRL_READOUT];
            swrst_reg        <= frame_dat_reg[`ADCC_CTRL_SWRST];
          end
          // Readback mode leaves the other registers untouched
          `ADCC_IDX_IFSEL: if (!ctrl_readout_reg) ifsel_reg <= frame_dat_reg;
          `ADCC_IDX_OFFS:  if (!ctrl_readout_reg) offs_reg <= frame_dat_reg & `ADCC_OFFS_WMASK;
          default: ;
        endcase
      end
      if (bus_wr) begin
        case (bus_idx)
          `ADCC_IDX_CTRL: begin
            ctrl_readout_reg <= wb_dat_i[`ADCC_CTRL_READOUT];
            swrst_reg        <= wb_dat_i[`ADCC_CTRL_SWRST];
          end
          `ADCC_IDX_IFSEL: ifsel_reg <= wb_dat_i[7:0];
          `ADCC_IDX_OFFS:  offs_reg  <= wb_dat_i[7:0] & `ADCC_OFFS_WMASK;
          default: ;
        endcase
      end
    end
  end

  // Bus answer, status clear on read, mask and interrupt
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      irq_reg  <= 1'b0;
    end else begin
      ack_reg  <= bus_req;
      rdat_reg <= 32'h0000_0000;
      // New events win over the read clear
      if (bus_req && !wb_we_i && bus_idx == `ADCC_IDX_STAT) begin
        stat_reg <= events;
      end else begin
        stat_reg <= stat_reg | events;
      end
      if (bus_wr && bus_idx == `ADCC_IDX_MASK) begin
        mask_reg <= wb_dat_i[2:0];
      end
      if (bus_req && !wb_we_i) begin
        case (bus_idx)
          `ADCC_IDX_STAT:  rdat_reg <= {29'h0, stat_reg};
          `ADCC_IDX_MASK:  rdat_reg <= {29'h0, mask_reg};
          `ADCC_IDX_STATE: rdat_reg <= {27'h0, hwrst_s, standby, use_cmos, twos, oe_s};
          default:         rdat_reg <= {24'h0, cfg_read(bus_idx)};
        endcase
      end
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  assign wb_ack_o                 = ack_reg;
  assign wb_dat_o                 = rdat_reg;
  assign irq_o                    = irq_reg;
  assign range_flag_or_readback_o = pin_out_reg;
  assign lane_true_o              = lane_reg;
  assign lane_comp_o              = ~lane_reg & {7{lvds_en}};
  assign forwarded_clock_true_o   = fwd_reg;
  assign forwarded_clock_comp_o   = ~fwd_reg & lvds_en;
  assign lane_oe_o                = lvds_en;
  assign cmos_data_o              = cmos_reg;
  assign cmos_clock_o             = cmos_clk_reg;
  assign cmos_oe_o                = cmos_en;
  assign standby_o                = standby;
  assign offset_loop_update_o     = loop_pulse_reg;
endmodule // adcc_core
`default_nettype wire

/* File: verification/adcc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on bus timing, buffer gating and output lanes
module adcc_checker (
  input wire logic        clk_i,                  // System clock
  input wire logic        rst_i,                  // Synchronous reset
  input wire logic        wb_cyc_i,               // Bus cycle
  input wire logic        wb_stb_i,               // Bus strobe
  input wire logic        wb_ack_o,               // Bus acknowledge
  input wire logic [31:0] wb_dat_o,               // Bus read data
  input wire logic        cfg_reset_i,            // Hardware reset pin
  input wire logic        cfg_serial_data_in_i,   // Serial data / standby pin
  input wire logic        out_enable_i,           // Output enable pin
  input wire logic        standby_o,              // Standby state
  input wire logic        lane_oe_o,              // Lane buffers enabled
  input wire logic        cmos_oe_o,              // Parallel buffers enabled
  input wire logic [6:0]  lane_true_o,            // Lanes, true
  input wire logic [6:0]  lane_comp_o,            // Lanes, complement
  input wire logic        forwarded_clock_true_o, // Forwarded clock, true
  input wire logic        forwarded_clock_comp_o, // Forwarded clock, complement
  input wire logic        offset_loop_update_o    // Loop period pulse
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request waiting for its answer
  sequence bus_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  // Buffers held off, or held on, for two cycles
  sequence lanes_off; !lane_oe_o [*2]; endsequence
  sequence lanes_on; lane_oe_o [*2]; endsequence
  // Pins settled through the synchroniser
  sequence sby_pins; (cfg_reset_i && cfg_serial_data_in_i) [*4]; endsequence
  ack_next_a: assert property (bus_taken |=> wb_ack_o) else $error("ack late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  standby_on_a: assert property (sby_pins |-> standby_o) else $error("standby missing");
  standby_off_a: assert property (!cfg_reset_i [*4] |-> !standby_o) else $error("standby in serial mode");
  oe_gate_a: assert property (!out_enable_i [*4] |-> !lane_oe_o && !cmos_oe_o) else $error("buffers on");
  lane_idle_a: assert property (lanes_off |-> lane_true_o == 7'h00 && !forwarded_clock_true_o)
    else $error("lanes active while off");
  lane_comp_a: assert property (lanes_on |-> lane_comp_o == ~lane_true_o &&
    forwarded_clock_comp_o == ~forwarded_clock_true_o) else $error("complement wrong");
  iface_excl_a: assert property (!(lane_oe_o && cmos_oe_o)) else $error("both interfaces on");
  update_gap_a: assert property (offset_loop_update_o |=> !offset_loop_update_o [*8])
    else $error("loop pulses too close");
endmodule // adcc_checker
bind adcc_core adcc_checker chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .cfg_reset_i(cfg_reset_i), .cfg_serial_data_in_i(cfg_serial_data_in_i),
  .out_enable_i(out_enable_i), .standby_o(standby_o), .lane_oe_o(lane_oe_o), .cmos_oe_o(cmos_oe_o),
  .lane_true_o(lane_true_o), .lane_comp_o(lane_comp_o), .forwarded_clock_true_o(forwarded_clock_true_o),
  .forwarded_clock_comp_o(forwarded_clock_comp_o), .offset_loop_update_o(offset_loop_update_o));
`default_nettype wire

/* File: verification/adcc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Board controller: serial configuration frames and the sample clock
module adcc_host_model (
  input  wire logic clk_i,   // System clock
  input  wire logic pin_i,   // Status pin from the converter
  output var  logic sclk_o,  // Serial clock, still outside frames
  output var  logic cfg_serial_data_in_o, // Serial data or standby level
  output var  logic sel_n_o, // Port select, low active
  output var  logic smp_t_o, // Sample clock, true
  output var  logic smp_c_o  // Sample clock, complement
);
  // Idle levels: clock low, select high, data pulled down
  initial begin
    sclk_o  = 1'b0;
    sel_n_o = 1'b1;
    cfg_serial_data_in_o = 1'b0;
    smp_t_o = 1'b0;
    smp_c_o = 1'b1;
  end
  // Free-running 400 ns sample clock, off the system clock phase
  initial begin
    #13;
    forever begin
      #200;
      smp_t_o = ~smp_t_o;
      smp_c_o = ~smp_c_o;
    end
  end
  // Level on the data pin while in direct mode
  task automatic set_standby(input logic b);
    @(posedge clk_i) cfg_serial_data_in_o <= b;
  endtask
  // One 16-bit frame, MSB first; readback bits gathered after falls 8..15
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] rb);
    logic [15:0] w;
    integer      i;
    begin
      w  = {a, d};
      rb = 8'h00;
      @(posedge clk_i) sel_n_o <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge clk_i) cfg_serial_data_in_o <= w[15-i];
        repeat (5) @(posedge clk_i);
        if (i >= 8) rb[15-i] = pin_i;
        @(posedge clk_i) sclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      sel_n_o <= 1'b1;
      cfg_serial_data_in_o <= 1'b0;
    end
  endtask
endmodule // adcc_host_model
`default_nettype wire

/* File: verification/adc_control_pin_modes_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defines.vh"
// Bus and pin level tests of the control block
module adc_control_pin_modes_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cfg_rst = 1'b0, oe = 1'b1, rng = 1'b0;
  logic [9:0] adr = 10'h000;  // Bus address
  logic [31:0] wdat = 32'h0;  // Bus write data
  logic [3:0] sel = 4'hF;     // Byte selects
  logic [1:0] fmt = 2'h0;     // Format pin: bit1 parallel, bit0 twos
  logic [13:0] smp = 14'h2A5C; // Converter word
  wire [31:0] rdat;
  wire ack, irq, pin, ftr, fcm, loe, cclk, coe, sby, upd, sclk, sdat, seln, st, sc;
  wire [6:0] lt, lc;
  wire [13:0] cdat;
  integer err_count = 0, n_tests = 0, i, c, n;
  logic [31:0] r;
  logic [7:0] rb;
  logic [6:0] ev, od;
  // 20 MHz clock
  always #25 clk_i = ~clk_i;
  adcc_core #(.TC_BASE_LOG2(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .irq_o(irq), .cfg_reset_i(cfg_rst), .cfg_serial_clk_i(sclk), .cfg_serial_data_in_i(sdat),
    .cfg_port_select_i(seln), .out_enable_i(oe), .format_interface_select_i(fmt), .sample_clock_true_i(st),
    .sample_clock_comp_i(sc), .adc_data_i(smp), .adc_range_i(rng), .range_flag_or_readback_o(pin),
    .forwarded_clock_true_o(ftr), .forwarded_clock_comp_o(fcm), .lane_true_o(lt), .lane_comp_o(lc),
    .lane_oe_o(loe), .cmos_data_o(cdat), .cmos_clock_o(cclk), .cmos_oe_o(coe), .standby_o(sby),
    .offset_loop_update_o(upd));
  adcc_host_model host (.clk_i(clk_i), .pin_i(pin), .sclk_o(sclk), .cfg_serial_data_in_o(sdat), .sel_n_o(seln),
    .smp_t_o(st), .smp_c_o(sc));
  // Compare one result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i) begin cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= d; end
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Clock cycles between two loop pulses
  task automatic gap(output integer k);
    while (upd !== 1'b1) @(posedge clk_i);
    k = 0;
    do begin @(posedge clk_i); k = k + 1; end while (upd !== 1'b1);
  endtask
  // Report and end the run
  task automatic close_out;
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk_i);
    err_count = err_count + 1;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i) cfg_rst <= 1'b1;
    repeat (4) @(posedge clk_i);
    cfg_rst <= 1'b0;
    repeat (4) @(posedge clk_i);
    // Defaults and an unmapped index
    wb(0, `ADCC_IDX_CTRL, 0, r); chk(r, `ADCC_CTRL_RST);
    wb(0, `ADCC_IDX_IFSEL, 0, r); chk(r, `ADCC_IFSEL_RST);
    wb(0, 8'h10, 0, r); chk(r, 32'h0);
    // Low bits beside the time code stay zero
    wb(1, `ADCC_IDX_OFFS, 32'h2F, r); wb(0, `ADCC_IDX_OFFS, 0, r); chk(r, 32'h2C);
    // Loop period doubles per code
    for (c = 0; c < 3; c = c + 1) begin
      wb(1, `ADCC_IDX_OFFS, c << 2, r);
      gap(n); gap(n); gap(n); chk(n, 32 << c);
    end
    wb(1, `ADCC_IDX_MASK, 32'h04, r); gap(n); repeat (2) @(posedge clk_i); chk(irq, 1);
    wb(0, `ADCC_IDX_STAT, 0, r); chk(r & 32'h4, 32'h4);
    wb(1, `ADCC_IDX_MASK, 32'h00, r); repeat (2) @(posedge clk_i); chk(irq, 0);
    // Interface field against the format pin
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge clk_i) fmt <= {i[2], 1'b0};
      host.frame(`ADCC_IDX_IFSEL, {i[1:0], 6'h00}, rb);
      repeat (8) @(posedge clk_i);
      c = (i[1:0] == 2'h3) ? 1 : (i[1:0] == 2'h1) ? 0 : i[2];
      chk(coe, c); chk(loe, !c);
    end
    wb(0, `ADCC_IDX_STAT, 0, r); chk(r & 32'h2, 32'h2);
    // Paired bits on differential lanes
    host.frame(`ADCC_IDX_IFSEL, 8'h40, rb);
    for (i = 0; i < 7; i = i + 1) begin ev[i] = smp[2*i]; od[i] = smp[2*i+1]; end
    repeat (24) @(posedge clk_i);
    while (ftr !== 1'b1) @(posedge clk_i);
    chk(lt, ev);
    while (ftr !== 1'b0) @(posedge clk_i);
    chk(lt, od);
    // Parallel data in both codings
    host.frame(`ADCC_IDX_IFSEL, 8'hC0, rb);
    @(posedge clk_i) fmt <= 2'h1;
    repeat (24) @(posedge clk_i); chk(cdat, smp ^ 14'h2000);
    @(posedge clk_i) fmt <= 2'h0;
    repeat (24) @(posedge clk_i);
    while (cclk !== 1'b1) @(posedge clk_i);
    chk(cdat, smp);
    // Range flag, its event, and readback on the same pin
    @(posedge clk_i) rng <= 1'b1;
    wb(1, `ADCC_IDX_MASK, 32'h01, r); repeat (16) @(posedge clk_i); chk(pin, 1); chk(irq, 1);
    @(posedge clk_i) rng <= 1'b0;
    repeat (16) @(posedge clk_i);
    wb(0, `ADCC_IDX_STAT, 0, r); chk(r & 32'h1, 32'h1);
    wb(0, `ADCC_IDX_STAT, 0, r); chk(r & 32'h1, 32'h0);
    wb(1, `ADCC_IDX_CTRL, 32'h01, r);
    host.frame(`ADCC_IDX_OFFS, 8'h00, rb); chk(rb, 8'h08);
    wb(1, `ADCC_IDX_CTRL, 32'h02, r);
    wb(0, `ADCC_IDX_IFSEL, 0, r); chk(r, `ADCC_IFSEL_RST);
    // Output enable low
    @(posedge clk_i) oe <= 1'b0;
    repeat (8) @(posedge clk_i); chk(coe, 0); chk(loe, 0);
    @(posedge clk_i) oe <= 1'b1;
    // Direct mode: defaults held, data pin is standby
    @(posedge clk_i) cfg_rst <= 1'b1;
    host.set_standby(1'b1);
    repeat (6) @(posedge clk_i); chk(sby, 1);
    wb(0, `ADCC_IDX_STATE, 0, r); chk(r, 32'h19);
    wb(1, `ADCC_IDX_OFFS, 32'h2C, r); wb(0, `ADCC_IDX_OFFS, 0, r); chk(r, `ADCC_OFFS_RST);
    host.set_standby(1'b0);
    repeat (6) @(posedge clk_i); chk(sby, 0);
    @(posedge clk_i) cfg_rst <= 1'b0;
    repeat (4) @(posedge clk_i);
    close_out;
  end
endmodule // adc_control_pin_modes_tb_top
`default_nettype wire
